// ===== sof_pkg.sv
// package for the stream output formatter: register offsets, field positions, reset values
// assumes one 200 MHz clock and a byte addressed 64KB local memory made of four banks
// Functional notes
// - input samples are complex, 24 bits real and 24 bits imaginary
// - 16-bit start address spans all four 16KB banks, any bank as destination
// - sample count holds samples per iteration minus one, in samples
// - samples beyond the count in an iteration are discarded
// - each written sample lands at previous address plus the sample stride
// - each iteration starts at previous start plus the iteration offset
// - leading skip samples are dropped, count plus one minus skip stored
// - real select stores only real part, otherwise real and imaginary
// - width select 0 gives 16-bit parts, 1 gives 32-bit parts
// - signed mode sign-extends added bits and saturates signed on removal
// - 8-bit scale sets the shift used in width conversion
// - conjugate on complex output negates the imaginary part
// - 4-bit status flags per-bank dma collisions, msb is bank zero
// - a set mask bit suppresses that bank's collision indication
// - writing one to a clear bit clears that collision flag
// - 16-bit output drops scale low bits and saturates the top excess
// - 32-bit output extends top by scale bits, pads 8 minus scale zeros
// - bit-reversed transform output is stored in natural index order
// - one complex sample per clock is accepted and written
package sof_pkg;

  // ****************************
  // register offsets
  // ****************************
  localparam logic [7:0] SOF_OFS_START = 8'h00;
  localparam logic [7:0] SOF_OFS_COUNT = 8'h04;
  localparam logic [7:0] SOF_OFS_STRIDE = 8'h08;
  localparam logic [7:0] SOF_OFS_ITER_OFS = 8'h0C;
  localparam logic [7:0] SOF_OFS_SKIP = 8'h10;
  localparam logic [7:0] SOF_OFS_FORMAT = 8'h14;
  localparam logic [7:0] SOF_OFS_COLL_STAT = 8'h18;
  localparam logic [7:0] SOF_OFS_COLL_MASK = 8'h1C;
  localparam logic [7:0] SOF_OFS_COLL_CLR = 8'h20;
  localparam logic [7:0] SOF_OFS_CTRL = 8'h24;
  localparam logic [7:0] SOF_OFS_ITERS = 8'h28;
  localparam logic [7:0] SOF_OFS_SRC_COUNT = 8'h2C;
  localparam logic [7:0] SOF_OFS_XFORM = 8'h30;

  // ****************************
  // field positions
  // ****************************
  localparam int SOF_FMT_REAL_BIT = 0;
  localparam int SOF_FMT_WIDE_BIT = 1;
  localparam int SOF_FMT_SIGNED_BIT = 2;
  localparam int SOF_FMT_CONJ_BIT = 3;
  localparam int SOF_FMT_SCALE_LSB = 8;
  localparam int SOF_CTRL_START_BIT = 0;
  localparam int SOF_XFORM_REV_BIT = 4;

  // ****************************
  // widths and limits
  // ****************************
  localparam int SOF_SAMPLE_W = 24;
  localparam int SOF_ADDR_W = 16;
  localparam int SOF_COUNT_W = 12;
  localparam int SOF_SKIP_W = 10;
  localparam int SOF_SCALE_W = 8;
  localparam int SOF_BANKS = 4;
  localparam int SOF_STRIDE_W = 15;
  localparam logic [7:0] SOF_SCALE_MAX = 8'h08;

  // ****************************
  // reset values
  // ****************************
  localparam logic [15:0] SOF_RST_START = 16'h0000;
  localparam logic [11:0] SOF_RST_COUNT = 12'h000;
  localparam logic [14:0] SOF_RST_STRIDE = 15'h0000;
  localparam logic [9:0] SOF_RST_SKIP = 10'h000;
  localparam logic [7:0] SOF_RST_SCALE = 8'h00;
  localparam logic [3:0] SOF_RST_BANK = 4'h0;
  localparam logic [3:0] SOF_RST_LOG2 = 4'h0;

  // memory write size codes
  localparam logic [1:0] SOF_SIZE_2B = 2'h1;
  localparam logic [1:0] SOF_SIZE_4B = 2'h2;
  localparam logic [1:0] SOF_SIZE_8B = 2'h3;

endpackage

// ===== sof_top.sv
// stream output formatter: register file, sample formatting and 2-D destination addressing
// assumes the sample stream, memory port and dma bank flags all run on clk
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module sof_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // sample stream from the computational unit
  input wire logic in_valid,
  input wire logic [sof_pkg::SOF_SAMPLE_W-1:0] in_re,
  input wire logic [sof_pkg::SOF_SAMPLE_W-1:0] in_im,
  output logic in_ready,
  // destination memory write port
  output logic mem_we,
  output logic [sof_pkg::SOF_ADDR_W-1:0] mem_addr,
  output logic [63:0] mem_wdata,
  output logic [1:0] mem_size,
  // dma bank activity, bit i is bank i
  input wire logic [sof_pkg::SOF_BANKS-1:0] dma_bank_access,
  // level, high while an unmasked collision flag is set
  output logic coll_err
);
  import sof_pkg::*;

  // ****************************
  // registers
  // ****************************
  logic [SOF_ADDR_W-1:0] start_reg;
  logic [SOF_COUNT_W-1:0] count_reg;
  logic [SOF_STRIDE_W-1:0] stride_reg;
  logic [SOF_STRIDE_W-1:0] iter_ofs_reg;
  logic [SOF_SKIP_W-1:0] skip_reg;
  logic real_reg;
  logic wide_reg;
  logic signed_reg;
  logic conj_reg;
  logic [SOF_SCALE_W-1:0] scale_reg;
  logic [SOF_BANKS-1:0] coll_stat_reg;
  logic [SOF_BANKS-1:0] coll_mask_reg;
  logic [SOF_COUNT_W-1:0] iters_reg;
  logic [SOF_COUNT_W-1:0] src_count_reg;
  logic rev_reg;
  logic [3:0] log2_reg;
  logic busy_reg;
  logic [SOF_COUNT_W-1:0] idx_reg;
  logic [SOF_COUNT_W-1:0] iter_reg;
  logic [SOF_ADDR_W-1:0] base_reg;

  logic wr_hit;
  logic take;
  logic last_in_iter;
  logic [SOF_COUNT_W-1:0] nat_idx;
  logic [SOF_COUNT_W:0] rel_idx;
  logic keep;
  logic [27:0] offset_bytes;
  logic [31:0] re_word;
  logic [31:0] im_word;
  logic [SOF_SCALE_W-1:0] scale_eff;

  assign wr_hit = reg_wr;
  assign take = in_valid && busy_reg;
  assign last_in_iter = (idx_reg == src_count_reg);

  // ****************************
  // helper functions
  // ****************************
  // natural index of a bit-reversed arrival index for a 2^log2 transform
  function automatic logic [SOF_COUNT_W-1:0] bit_rev(input logic [SOF_COUNT_W-1:0] k,
                                                     input logic [3:0] lg);
    logic [SOF_COUNT_W-1:0] r;
    r = k;
    for (int i = 0; i < SOF_COUNT_W; i++) begin
      if (i < int'(lg)) begin
        r[i] = k[int'(lg) - 1 - i];
      end
    end
    return r;
  endfunction

  // one 24-bit part to a 16-bit or 32-bit word, scale clamped to 8
  function automatic logic [31:0] fmt_part(input logic [23:0] x, input logic [7:0] sc,
                                           input logic sgn, input logic wide);
    logic [31:0] ext;
    logic [31:0] shr;
    logic [31:0] res;
    ext = sgn ? {{8{x[23]}}, x} : {8'h00, x};
    res = 32'h00000000;
    if (wide) begin
      res = ext << (SOF_SCALE_MAX - sc);
    end else begin
      shr = sgn ? 32'($signed(ext) >>> sc) : (ext >> sc);
      if (sgn) begin
        if ($signed(shr) > $signed(32'h00007FFF)) begin
          res = 32'h00007FFF;
        end else if ($signed(shr) < $signed(32'hFFFF8000)) begin
          res = 32'h00008000;
        end else begin
          res = {16'h0000, shr[15:0]};
        end
      end else begin
        res = (shr > 32'h0000FFFF) ? 32'h0000FFFF : shr;
      end
    end
    return res;
  endfunction

  // ****************************
  // register writes
  // ****************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= SOF_RST_START;
      count_reg <= SOF_RST_COUNT;
      stride_reg <= SOF_RST_STRIDE;
      iter_ofs_reg <= SOF_RST_STRIDE;
      skip_reg <= SOF_RST_SKIP;
      real_reg <= 1'b0;
      wide_reg <= 1'b0;
      signed_reg <= 1'b0;
      conj_reg <= 1'b0;
      scale_reg <= SOF_RST_SCALE;
      coll_mask_reg <= SOF_RST_BANK;
      iters_reg <= SOF_RST_COUNT;
      src_count_reg <= SOF_RST_COUNT;
      rev_reg <= 1'b0;
      log2_reg <= SOF_RST_LOG2;
    end else if (wr_hit) begin
      unique case (reg_addr)
        SOF_OFS_START: start_reg <= reg_wdata[SOF_ADDR_W-1:0];
        SOF_OFS_COUNT: count_reg <= reg_wdata[SOF_COUNT_W-1:0];
        SOF_OFS_STRIDE: stride_reg <= reg_wdata[SOF_STRIDE_W-1:0];
        SOF_OFS_ITER_OFS: iter_ofs_reg <= reg_wdata[SOF_STRIDE_W-1:0];
        SOF_OFS_SKIP: skip_reg <= reg_wdata[SOF_SKIP_W-1:0];
        SOF_OFS_FORMAT: begin
          real_reg <= reg_wdata[SOF_FMT_REAL_BIT];
          wide_reg <= reg_wdata[SOF_FMT_WIDE_BIT];
          signed_reg <= reg_wdata[SOF_FMT_SIGNED_BIT];
          conj_reg <= reg_wdata[SOF_FMT_CONJ_BIT];
          scale_reg <= reg_wdata[SOF_FMT_SCALE_LSB +: SOF_SCALE_W];
        end
        SOF_OFS_COLL_MASK: coll_mask_reg <= reg_wdata[SOF_BANKS-1:0];
        SOF_OFS_ITERS: iters_reg <= reg_wdata[SOF_COUNT_W-1:0];
        SOF_OFS_SRC_COUNT: src_count_reg <= reg_wdata[SOF_COUNT_W-1:0];
        SOF_OFS_XFORM: begin
          rev_reg <= reg_wdata[SOF_XFORM_REV_BIT];
          log2_reg <= reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************
  // register reads
  // ****************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SOF_OFS_START: reg_rdata <= {16'h0000, start_reg};
        SOF_OFS_COUNT: reg_rdata <= {20'h00000, count_reg};
        SOF_OFS_STRIDE: reg_rdata <= {17'h00000, stride_reg};
        SOF_OFS_ITER_OFS: reg_rdata <= {17'h00000, iter_ofs_reg};
        SOF_OFS_SKIP: reg_rdata <= {22'h000000, skip_reg};
        SOF_OFS_FORMAT: reg_rdata <= {16'h0000, scale_reg, 4'h0,
                                      conj_reg, signed_reg, wide_reg, real_reg};
        SOF_OFS_COLL_STAT: reg_rdata <= {28'h0000000, coll_stat_reg};
        SOF_OFS_COLL_MASK: reg_rdata <= {28'h0000000, coll_mask_reg};
        SOF_OFS_CTRL: reg_rdata <= {31'h00000000, busy_reg};
        SOF_OFS_ITERS: reg_rdata <= {20'h00000, iters_reg};
        SOF_OFS_SRC_COUNT: reg_rdata <= {20'h00000, src_count_reg};
        SOF_OFS_XFORM: reg_rdata <= {27'h0000000, rev_reg, log2_reg};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ****************************
  // iteration sequencing
  // ****************************
  // a start while busy is ignored so a running pass is never restarted mid-iteration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      idx_reg <= SOF_RST_COUNT;
      iter_reg <= SOF_RST_COUNT;
      base_reg <= SOF_RST_START;
    end else if (!busy_reg) begin
      if (wr_hit && reg_addr == SOF_OFS_CTRL && reg_wdata[SOF_CTRL_START_BIT]) begin
        busy_reg <= 1'b1;
        idx_reg <= SOF_RST_COUNT;
        iter_reg <= SOF_RST_COUNT;
        base_reg <= start_reg;
      end
    end else if (take) begin
      if (last_in_iter) begin
        idx_reg <= SOF_RST_COUNT;
        iter_reg <= iter_reg + 12'h001;
        base_reg <= base_reg + {1'b0, iter_ofs_reg};
        if (iter_reg == iters_reg) begin
          busy_reg <= 1'b0;
        end
      end else begin
        idx_reg <= idx_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= busy_reg && !(take && last_in_iter && iter_reg == iters_reg);
    end
  end

  // ****************************
  // addressing
  // ****************************
  // writes go straight to the natural slot, so no reorder buffer is needed
  assign nat_idx = rev_reg ? bit_rev(idx_reg, log2_reg) : idx_reg;
  assign rel_idx = {1'b0, nat_idx} - {3'h0, skip_reg};
  assign keep = (nat_idx >= {2'h0, skip_reg}) && (nat_idx <= count_reg);
  assign offset_bytes = 28'(rel_idx[SOF_COUNT_W-1:0] * stride_reg);

  // ****************************
  // formatting
  // ****************************
  assign scale_eff = (scale_reg > SOF_SCALE_MAX) ? SOF_SCALE_MAX : scale_reg;
  assign re_word = fmt_part(in_re, scale_eff, signed_reg, wide_reg);

  // negating the most negative input would wrap, so it saturates instead
  always_comb begin
    logic [23:0] im_src;
    im_src = in_im;
    if (conj_reg && !real_reg) begin
      im_src = (in_im == 24'h800000) ? 24'h7FFFFF : 24'(-in_im);
    end
    im_word = fmt_part(im_src, scale_eff, signed_reg, wide_reg);
  end

  // ****************************
  // memory write port
  // ****************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we <= 1'b0;
      mem_addr <= SOF_RST_START;
      mem_wdata <= 64'h0000000000000000;
      mem_size <= SOF_SIZE_2B;
    end else begin
      mem_we <= take && keep;
      mem_addr <= base_reg + offset_bytes[SOF_ADDR_W-1:0];
      if (real_reg) begin
        mem_wdata <= {32'h00000000, wide_reg ? re_word : {16'h0000, re_word[15:0]}};
        mem_size <= wide_reg ? SOF_SIZE_4B : SOF_SIZE_2B;
      end else if (wide_reg) begin
        mem_wdata <= {im_word, re_word};
        mem_size <= SOF_SIZE_8B;
      end else begin
        mem_wdata <= {32'h00000000, im_word[15:0], re_word[15:0]};
        mem_size <= SOF_SIZE_4B;
      end
    end
  end

  // ****************************
  // bank collision flags
  // ****************************
  // status bit 3 is bank 0; a new collision beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_stat_reg <= SOF_RST_BANK;
    end else begin
      for (int b = 0; b < SOF_BANKS; b++) begin
        if (mem_we && mem_addr[15:14] == 2'(b) && dma_bank_access[b]) begin
          coll_stat_reg[SOF_BANKS-1-b] <= 1'b1;
        end else if (wr_hit && reg_addr == SOF_OFS_COLL_CLR &&
                     reg_wdata[SOF_BANKS-1-b]) begin
          coll_stat_reg[SOF_BANKS-1-b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_err <= 1'b0;
    end else begin
      coll_err <= |(coll_stat_reg & ~coll_mask_reg);
    end
  end

endmodule

// ===== sof_top_properties.sv
// checker for the stream output formatter ports
// assumes one clock domain and the sof_pkg register map
`timescale 1ns/1ps
module sof_top_properties
  import sof_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // stream and memory
  input wire logic in_valid,
  input wire logic mem_we,
  input wire logic [sof_pkg::SOF_ADDR_W-1:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [sof_pkg::SOF_BANKS-1:0] dma_bank_access,
  input wire logic coll_err
);
  // ****
  // helper state
  // ****
  logic [1:0] fmt_q;
  logic [3:0] mask_q;
  logic [1:0] size_exp;
  logic hit;
  logic [3:0] coll_q;
  // format mirror, so the size code is judged without the body
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q <= 2'h0;
    end else if (reg_wr && reg_addr == SOF_OFS_FORMAT) begin
      fmt_q <= reg_wdata[1:0];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 4'h0;
    end else if (reg_wr && reg_addr == SOF_OFS_COLL_MASK) begin
      mask_q <= reg_wdata[3:0];
    end
  end
  // status mirror: msb is bank zero, a collision beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coll_q <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (hit && mem_addr[15:14] == 2'(b)) begin
          coll_q[3 - b] <= 1'h1;
        end else if (reg_wr && reg_addr == SOF_OFS_COLL_CLR && reg_wdata[3 - b]) begin
          coll_q[3 - b] <= 1'h0;
        end
      end
    end
  end
  assign size_exp = fmt_q[0] ? (fmt_q[1] ? SOF_SIZE_4B : SOF_SIZE_2B)
    : (fmt_q[1] ? SOF_SIZE_8B : SOF_SIZE_4B);
  assign hit = mem_we && dma_bank_access[mem_addr[15:14]];
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  a_status_width: assert property ($past(reg_rd) && $past(reg_addr) == SOF_OFS_COLL_STAT
    |-> reg_rdata == {28'h0, $past(coll_q)}) else $error("status read wrong");
  a_write_cause: assert property (mem_we |-> $past(in_valid))
    else $error("memory write without a sample");
  a_size_code: assert property (mem_we |-> mem_size == size_exp)
    else $error("wrong write size");
  a_coll_raise: assert property (hit && mask_q == 4'h0 |-> ##2 coll_err)
    else $error("collision not flagged");
  a_err_sticky: assert property (coll_err && !$past(reg_wr) |=> coll_err)
    else $error("error flag dropped by itself");
  a_clear_drops: assert property (reg_wr && reg_addr == SOF_OFS_COLL_CLR
    && reg_wdata[3:0] == 4'hF && !hit |-> ##2 !coll_err) else $error("clear ignored");
  a_mask_hides: assert property (reg_wr && reg_addr == SOF_OFS_COLL_MASK
    && reg_wdata[3:0] == 4'hF |-> ##2 !coll_err) else $error("mask ignored");
  c_hit: cover property (hit);
  c_wide: cover property (mem_we && mem_size == SOF_SIZE_8B);
  c_err_gone: cover property (coll_err ##1 !coll_err);
endmodule

// ===== sof_sample_src.sv
// partner model: the computational unit streaming complex samples
// assumes the bench pulses go for one cycle with count and base values set
`timescale 1ns/1ps
module sof_sample_src (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench control
  input wire logic go,
  input wire logic [7:0] n_smp,
  input wire logic [23:0] base_re,
  input wire logic [23:0] base_im,
  // sample stream
  output logic in_valid,
  output logic [23:0] in_re,
  output logic [23:0] in_im
);
  // ****
  // stream source
  // ****
  logic [7:0] left_reg;
  logic [23:0] k_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_reg <= 8'h00;
      k_reg <= 24'h0;
      in_valid <= 1'h0;
      in_re <= 24'h0;
      in_im <= 24'h0;
    end else if (go) begin
      left_reg <= n_smp;
      k_reg <= 24'h0;
    end else if (left_reg != 8'h00) begin
      in_valid <= 1'h1;
      in_re <= base_re + k_reg;
      in_im <= base_im + k_reg;
      k_reg <= k_reg + 24'h1;
      left_reg <= left_reg - 8'h01;
    end else begin
      // no stale sample between frames, so a late take shows as bad data
      in_valid <= 1'h0;
      in_re <= ~in_re;
      in_im <= ~in_im;
    end
  end
endmodule

// ===== tb_sof_top.sv
// self-checking bench for the stream output formatter
// assumes sof_sample_src feeds the stream and the bench logs the memory port
`timescale 1ns/1ps
module tb_sof_top;
  import sof_pkg::*;
  // ****
  // signals
  // ****
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0, go = 1'h0;
  logic [7:0] reg_addr = 8'h00, n_smp = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic [23:0] in_re, in_im, base_re = 24'h0, base_im = 24'h0;
  logic in_valid, in_ready, mem_we, coll_err;
  logic [15:0] mem_addr;
  logic [63:0] mem_wdata;
  logic [1:0] mem_size;
  logic [3:0] dma_bank_access = 4'h0;
  logic [15:0] got_a[$];
  logic [63:0] got_d[$];
  logic [1:0] got_s[$];
  logic [7:0] ofs[5] = '{SOF_OFS_START, SOF_OFS_COUNT, SOF_OFS_STRIDE, SOF_OFS_ITER_OFS,
    SOF_OFS_SKIP};
  int wd[5] = '{16, 12, 15, 15, 10};
  int err_total = 0;
  int checked = 0;
  sof_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_re(in_re), .in_im(in_im), .in_ready(in_ready), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_size(mem_size), .dma_bank_access(dma_bank_access),
    .coll_err(coll_err));
  sof_sample_src src_u (.clk(clk), .rst_n(rst_n), .go(go), .n_smp(n_smp), .base_re(base_re),
    .base_im(base_im), .in_valid(in_valid), .in_re(in_re), .in_im(in_im));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (mem_we === 1'h1) begin
      got_a.push_back(mem_addr);
      got_d.push_back(mem_wdata);
      got_s.push_back(mem_size);
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // strobes stay up between back-to-back writes; idle or rd drops them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_rd <= 1'h0;
    reg_wr <= 1'h1;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_wr <= 1'h0;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    repeat (n) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic int brev(input int k, input int lg);
    int r;
    r = 0;
    for (int i = 0; i < lg; i++) r = (r << 1) | ((k >> i) & 1);
    return r;
  endfunction
  function automatic logic [31:0] cvt(input logic [23:0] x, input logic neg,
      input logic [15:0] fm);
    longint y;
    int sc;
    sc = (fm[15:8] > 8'h08) ? 8 : int'(fm[15:8]);
    y = fm[2] ? longint'(signed'(x)) : longint'(x);
    if (neg) y = -y;
    if (neg && y > 64'sh7FFFFF) y = 64'sh7FFFFF;
    if (fm[1]) return 32'(y <<< (8 - sc));
    y = y >>> sc;
    if (fm[2]) return (y > 64'sh7FFF) ? 32'h7FFF : (y < -64'sh8000) ? 32'h8000 : 32'(16'(y));
    return (y > 64'shFFFF) ? 32'hFFFF : 32'(16'(y));
  endfunction
  task automatic pass(input logic [15:0] st, input logic [14:0] sd, input logic [14:0] io,
      input logic [11:0] cnt, input logic [9:0] sk, input logic [11:0] src,
      input logic [11:0] it, input logic [15:0] fm, input logic [4:0] xf,
      input logic [23:0] r0, input logic [23:0] i0);
    logic [15:0] ea[$];
    logic [63:0] ed[$];
    logic [63:0] m;
    logic [31:0] er, ei;
    logic [1:0] es;
    int j, n;
    got_a.delete();
    got_d.delete();
    got_s.delete();
    wr(SOF_OFS_START, {16'h0, st});
    wr(SOF_OFS_STRIDE, {17'h0, sd});
    wr(SOF_OFS_ITER_OFS, {17'h0, io});
    wr(SOF_OFS_COUNT, {20'h0, cnt});
    wr(SOF_OFS_SKIP, {22'h0, sk});
    wr(SOF_OFS_SRC_COUNT, {20'h0, src});
    wr(SOF_OFS_ITERS, {20'h0, it});
    wr(SOF_OFS_FORMAT, {16'h0, fm});
    wr(SOF_OFS_XFORM, {27'h0, xf});
    base_re <= r0;
    base_im <= i0;
    n_smp <= 8'((it + 1) * (src + 1));
    go <= 1'h1;
    wr(SOF_OFS_CTRL, 32'h1);
    go <= 1'h0;
    idle(1);
    @(negedge clk);
    chk(in_ready, 1'h1);
    @(posedge clk);
    for (int b = 0; b <= it; b++) begin
      for (int k = 0; k <= src; k++) begin
        j = b * (src + 1) + k;
        n = xf[4] ? brev(k, xf[3:0]) : k;
        if (n >= sk && n <= cnt) begin
          ea.push_back(16'(st + b * io + (n - sk) * sd));
          er = cvt(24'(r0 + j), 1'h0, fm);
          ei = cvt(24'(i0 + j), fm[3] & ~fm[0], fm);
          ed.push_back(fm[0] ? {32'h0, er} : fm[1] ? {ei, er} : {32'h0, ei[15:0], er[15:0]});
        end
      end
    end
    es = fm[0] ? (fm[1] ? SOF_SIZE_4B : SOF_SIZE_2B) : (fm[1] ? SOF_SIZE_8B : SOF_SIZE_4B);
    m = (fm[1:0] == 2'h1) ? 64'hFFFF : (fm[1:0] == 2'h2) ? 64'hFFFFFFFFFFFFFFFF : 64'hFFFFFFFF;
    j = 0;
    v = 32'h1;
    while (v[0] !== 1'h0 && j < 300) begin
      rd(SOF_OFS_CTRL, v);
      j++;
    end
    // a pass that never ends runs the poll out and counts as a mismatch here
    chk(v, 64'h0);
    idle(3);
    chk(in_ready, 1'h0);
    chk(got_a.size(), ea.size());
    foreach (ea[i]) begin
      chk(got_a[i], ea[i]);
      chk(got_d[i] & m, ed[i] & m);
      chk(got_s[i], es);
    end
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(SOF_OFS_COLL_STAT, v);
    chk(v, 64'h0);
    rd(8'h3C, v);
    chk(v, 64'h0);
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], v);
      chk(v, 64'h0);
      wr(ofs[i], 32'hFFFFFFFF);
      rd(ofs[i], v);
      chk(v, (64'h1 << wd[i]) - 64'h1);
    end
    // destination bank 3 while the dma touches it; source never shares it
    dma_bank_access <= 4'h8;
    pass(16'hC040, 15'h10, 15'h4, 12'h3, 10'h1, 12'h5, 12'h1, 16'h0804, 5'h0, 24'h123456,
      24'hFEDCBA);
    dma_bank_access <= 4'h0;
    rd(SOF_OFS_COLL_STAT, v);
    chk(v, 64'h1);
    chk(coll_err, 1'h1);
    wr(SOF_OFS_COLL_MASK, 32'hF);
    idle(3);
    chk(coll_err, 1'h0);
    rd(SOF_OFS_COLL_STAT, v);
    chk(v, 64'h1);
    wr(SOF_OFS_COLL_MASK, 32'h0);
    wr(SOF_OFS_COLL_CLR, 32'hF);
    idle(3);
    chk(coll_err, 1'h0);
    rd(SOF_OFS_COLL_STAT, v);
    chk(v, 64'h0);
    pass(16'h4000, 15'h7FFF, 15'h7FFF, 12'h2, 10'h0, 12'h2, 12'h1, 16'h0303, 5'h0,
      24'hFFFFFE, 24'h0);
    pass(16'h0010, 15'h8, 15'h0, 12'h7, 10'h0, 12'h7, 12'h0, 16'h000E, 5'h13, 24'h800003,
      24'h7FFFFF);
    pass(16'h8000, 15'h2, 15'h0, 12'h2, 10'h0, 12'h3, 12'h0, 16'h0001, 5'h0, 24'h00FFFE,
      24'h0);
    pass(16'h2000, 15'h4, 15'h40, 12'h1, 10'h1, 12'h1, 12'h2, 16'h030C, 5'h0, 24'h3FFFF0,
      24'hC00000);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
bind sof_top sof_top_properties chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .in_valid(in_valid), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
  .dma_bank_access(dma_bank_access), .coll_err(coll_err));
